/* rtl/bitops_core.sv */
// The Avalon-MM register port was decided locally.
module bitops_core
  import bitops_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [31:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RUN,
    ST_SYNC
  } exec_state_t;

  typedef struct packed {
    exec_state_t state;
    logic [3:0] cnt;
    logic [3:0] op;
    logic [31:0] target;
    logic [31:0] operand;
    logic [31:0] src_row_stride;
    logic [31:0] dst_row_stride;
    logic [31:0] mask_row_stride;
    logic [31:0] flags_word;
    logic [15:0] source_pitch_factor;
    logic [15:0] destination_pitch_factor;
    logic [15:0] mask_pitch_factor;
    logic [15:0] pixel_width;
    logic pend_valid;
    logic [3:0] pend_op;
    logic [15:0] pend_val;
    logic ack;
    logic [31:0] readdata;
  } core_state_t;

  core_state_t state_reg;
  core_state_t state_next;

  logic [3:0] sel_op;
  logic [31:0] sel_pitch;
  logic [15:0] factor;
  logic [3:0] factor_states;
  logic [31:0] rotated;
  logic [31:0] replicated;
  logic [4:0] scan_idx;
  logic req;
  logic cmd_stall;

  // Circular left rotate by a five-bit count
  function automatic logic [31:0] rotate_left(input logic [31:0] v, input logic [4:0] c);
    logic [63:0] dbl;
    dbl = {v, v} << c;
    return dbl[63:32];
  endfunction : rotate_left

  // Copy the low pixel across the word; illegal widths act as 32
  function automatic logic [31:0] replicate(input logic [31:0] v, input logic [15:0] pw);
    logic [4:0] mask;
    logic [31:0] res;
    unique case (pw)
      16'h0001: mask = 5'h00;
      16'h0002: mask = 5'h01;
      16'h0004: mask = 5'h03;
      16'h0008: mask = 5'h07;
      16'h0010: mask = 5'h0F;
      default: mask = 5'h1F;
    endcase
    res = v;
    for (int i = 0; i < 32; i++) begin
      res[i] = v[5'(i) & mask];
    end
    return res;
  endfunction : replicate

  // Machine states of a replicate by pixel width
  function automatic logic [3:0] rep_states(input logic [15:0] pw);
    logic [3:0] s;
    unique case (pw)
      16'h0001: s = STATES_REP_1;
      16'h0002: s = STATES_REP_2;
      16'h0004: s = STATES_REP_4;
      16'h0008: s = STATES_REP_8;
      16'h0010: s = STATES_REP_16;
      default: s = STATES_REP_32;
    endcase
    return s;
  endfunction : rep_states

  // Stride feeding the factor unit follows the starting or running op
  assign sel_op = (state_reg.state == ST_IDLE) ? writedata[3:0] : state_reg.op;

  always_comb begin
    unique case (sel_op)
      CMD_LOAD_DST_FACTOR: sel_pitch = state_reg.dst_row_stride;
      CMD_LOAD_MSK_FACTOR: sel_pitch = state_reg.mask_row_stride;
      default: sel_pitch = state_reg.src_row_stride;
    endcase
  end

  pitch_factor_unit factor_unit (
    .pitch(sel_pitch),
    .factor(factor),
    .states(factor_states)
  );

  // Datapath results from the current operands
  assign rotated = rotate_left(state_reg.target, state_reg.operand[4:0]);
  assign replicated = replicate(state_reg.target, state_reg.pixel_width);
  assign scan_idx = lsb_index(state_reg.operand);

  // Bus handshake: one wait cycle, commands stall while busy
  assign req = read | write;
  assign cmd_stall = write && address == ADDR_COMMAND && state_reg.state != ST_IDLE;
  assign waitrequest = req & ~state_reg.ack;

  always_comb begin
    state_next = state_reg;
    state_next.ack = req && !state_reg.ack && !cmd_stall;

    // Read data captured one edge before the answer
    if (read && !state_reg.ack) begin
      unique case (address)
        ADDR_SRC_FACTOR: state_next.readdata = {16'h0000, state_reg.source_pitch_factor};
        ADDR_DST_FACTOR: state_next.readdata = {16'h0000, state_reg.destination_pitch_factor};
        ADDR_PIX_WIDTH: state_next.readdata = {16'h0000, state_reg.pixel_width};
        ADDR_MSK_FACTOR: state_next.readdata = {16'h0000, state_reg.mask_pitch_factor};
        ADDR_TARGET: state_next.readdata = state_reg.target;
        ADDR_OPERAND: state_next.readdata = state_reg.operand;
        ADDR_SRC_STRIDE: state_next.readdata = state_reg.src_row_stride;
        ADDR_DST_STRIDE: state_next.readdata = state_reg.dst_row_stride;
        ADDR_MSK_STRIDE: state_next.readdata = state_reg.mask_row_stride;
        ADDR_FLAGS: state_next.readdata = state_reg.flags_word;
        ADDR_COMMAND: state_next.readdata = {28'h000_0000, state_reg.op};
        ADDR_STATUS: begin
          state_next.readdata = WORD_RESET;
          state_next.readdata[STAT_BUSY] = state_reg.state != ST_IDLE;
          state_next.readdata[STAT_PEND] = state_reg.pend_valid;
        end
        default: state_next.readdata = WORD_RESET;
      endcase
    end

    // Execution sequencer
    unique case (state_reg.state)
      ST_IDLE: begin
      end
      ST_RUN: begin
        if (state_reg.cnt != 4'h0) begin
          state_next.cnt = state_reg.cnt - 4'h1;
        end else begin
          state_next.state = ST_IDLE;
          unique case (state_reg.op)
            CMD_CIRCULAR_SHIFT: begin
              state_next.target = rotated;
              // Carry is the final bit zero, cleared by a zero count
              state_next.flags_word[FLAG_C] = (state_reg.operand[4:0] != 5'h00) & rotated[0];
              state_next.flags_word[FLAG_Z] = rotated == WORD_RESET;
            end
            CMD_LOWEST_SET_BIT: begin
              state_next.target = {27'h000_0000, scan_idx};
              state_next.flags_word[FLAG_Z] = state_reg.operand == WORD_RESET;
            end
            CMD_PIXEL_REPLICATE: begin
              state_next.target = replicated;
            end
            CMD_CARRY_FORCE: begin
              state_next.flags_word[FLAG_C] = 1'b1;
            end
            CMD_LOAD_DST_FACTOR, CMD_LOAD_MSK_FACTOR, CMD_LOAD_SRC_FACTOR: begin
              // Factor lands one cycle later through the pending slot
              state_next.pend_valid = 1'b1;
              state_next.pend_op = state_reg.op;
              state_next.pend_val = factor;
            end
            default: begin
            end
          endcase
        end
      end
      ST_SYNC: begin
        if (!state_reg.pend_valid) begin
          state_next.state = ST_IDLE;
        end
      end
      default: state_next.state = ST_IDLE;
    endcase

    // Register writes at the edge where waitrequest is low
    if (write && state_reg.ack) begin
      unique case (address)
        ADDR_SRC_FACTOR: state_next.source_pitch_factor =
          16'(be_merge({16'h0000, state_reg.source_pitch_factor}, writedata, byteenable));
        ADDR_DST_FACTOR: state_next.destination_pitch_factor =
          16'(be_merge({16'h0000, state_reg.destination_pitch_factor}, writedata, byteenable));
        ADDR_PIX_WIDTH: state_next.pixel_width =
          16'(be_merge({16'h0000, state_reg.pixel_width}, writedata, byteenable));
        ADDR_MSK_FACTOR: state_next.mask_pitch_factor =
          16'(be_merge({16'h0000, state_reg.mask_pitch_factor}, writedata, byteenable));
        ADDR_TARGET: state_next.target = be_merge(state_reg.target, writedata, byteenable);
        ADDR_OPERAND: state_next.operand = be_merge(state_reg.operand, writedata, byteenable);
        ADDR_SRC_STRIDE: state_next.src_row_stride = be_merge(state_reg.src_row_stride, writedata, byteenable);
        ADDR_DST_STRIDE: state_next.dst_row_stride = be_merge(state_reg.dst_row_stride, writedata, byteenable);
        ADDR_MSK_STRIDE: state_next.mask_row_stride = be_merge(state_reg.mask_row_stride, writedata, byteenable);
        ADDR_FLAGS: state_next.flags_word = be_merge(state_reg.flags_word, writedata, byteenable);
        ADDR_COMMAND: begin
          // Start a command; only taken while idle
          state_next.op = writedata[3:0];
          unique case (writedata[3:0])
            CMD_MEMORY_SYNC: begin
              state_next.state = ST_SYNC;
            end
            CMD_PIXEL_REPLICATE: begin
              state_next.state = ST_RUN;
              state_next.cnt = rep_states(state_reg.pixel_width) - 4'h1;
            end
            CMD_LOAD_DST_FACTOR, CMD_LOAD_MSK_FACTOR, CMD_LOAD_SRC_FACTOR: begin
              state_next.state = ST_RUN;
              state_next.cnt = factor_states - 4'h1;
            end
            CMD_CIRCULAR_SHIFT, CMD_LOWEST_SET_BIT, CMD_CARRY_FORCE: begin
              state_next.state = ST_RUN;
              state_next.cnt = STATES_SINGLE - 4'h1;
            end
            default: begin
            end
          endcase
        end
        default: begin
        end
      endcase
    end

    // Pending factor commit wins over a bus write in the same cycle
    if (state_reg.pend_valid) begin
      state_next.pend_valid = 1'b0;
      unique case (state_reg.pend_op)
        CMD_LOAD_DST_FACTOR: state_next.destination_pitch_factor = state_reg.pend_val;
        CMD_LOAD_MSK_FACTOR: state_next.mask_pitch_factor = state_reg.pend_val;
        default: state_next.source_pitch_factor = state_reg.pend_val;
      endcase
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg.state <= ST_IDLE;
      state_reg.cnt <= 4'h0;
      state_reg.op <= 4'h0;
      state_reg.target <= WORD_RESET;
      state_reg.operand <= WORD_RESET;
      state_reg.src_row_stride <= WORD_RESET;
      state_reg.dst_row_stride <= WORD_RESET;
      state_reg.mask_row_stride <= WORD_RESET;
      state_reg.flags_word <= WORD_RESET;
      state_reg.source_pitch_factor <= FACTOR_RESET;
      state_reg.destination_pitch_factor <= FACTOR_RESET;
      state_reg.mask_pitch_factor <= FACTOR_RESET;
      state_reg.pixel_width <= PIX_WIDTH_RESET;
      state_reg.pend_valid <= 1'b0;
      state_reg.pend_op <= 4'h0;
      state_reg.pend_val <= FACTOR_RESET;
      state_reg.ack <= 1'b0;
      state_reg.readdata <= WORD_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign readdata = state_reg.readdata;

endmodule : bitops_core

/* rtl/bitops_pkg.sv */
package bitops_pkg;

  // Register byte addresses
  localparam logic [31:0] ADDR_SRC_FACTOR = 32'hC000_0130;
  localparam logic [31:0] ADDR_DST_FACTOR = 32'hC000_0140;
  localparam logic [31:0] ADDR_PIX_WIDTH = 32'hC000_0150;
  localparam logic [31:0] ADDR_MSK_FACTOR = 32'hC000_0180;
  localparam logic [31:0] ADDR_TARGET = 32'hC000_0400;
  localparam logic [31:0] ADDR_OPERAND = 32'hC000_0404;
  localparam logic [31:0] ADDR_SRC_STRIDE = 32'hC000_0408;
  localparam logic [31:0] ADDR_DST_STRIDE = 32'hC000_040C;
  localparam logic [31:0] ADDR_MSK_STRIDE = 32'hC000_0410;
  localparam logic [31:0] ADDR_FLAGS = 32'hC000_0414;
  localparam logic [31:0] ADDR_COMMAND = 32'hC000_0418;
  localparam logic [31:0] ADDR_STATUS = 32'hC000_041C;

  // Values after reset
  localparam logic [15:0] PIX_WIDTH_RESET = 16'h0020;
  localparam logic [15:0] FACTOR_RESET = 16'h0000;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  // Flag positions in the flags word
  localparam int FLAG_N = 31;
  localparam int FLAG_C = 30;
  localparam int FLAG_Z = 29;
  localparam int FLAG_V = 28;

  // Status register bit positions
  localparam int STAT_BUSY = 0;
  localparam int STAT_PEND = 1;

  // Command codes written to the command register
  localparam logic [3:0] CMD_CIRCULAR_SHIFT = 4'h1;
  localparam logic [3:0] CMD_LOWEST_SET_BIT = 4'h2;
  localparam logic [3:0] CMD_PIXEL_REPLICATE = 4'h3;
  localparam logic [3:0] CMD_CARRY_FORCE = 4'h4;
  localparam logic [3:0] CMD_LOAD_DST_FACTOR = 4'h5;
  localparam logic [3:0] CMD_LOAD_MSK_FACTOR = 4'h6;
  localparam logic [3:0] CMD_LOAD_SRC_FACTOR = 4'h7;
  localparam logic [3:0] CMD_MEMORY_SYNC = 4'h8;

  // Machine-state counts, one clock cycle per state
  localparam logic [3:0] STATES_SINGLE = 4'h1;
  localparam logic [3:0] STATES_FACTOR_POW2 = 4'h4;
  localparam logic [3:0] STATES_FACTOR_TWO = 4'h6;
  localparam logic [3:0] STATES_FACTOR_OTHER = 4'h3;
  localparam logic [3:0] STATES_REP_32 = 4'h2;
  localparam logic [3:0] STATES_REP_16 = 4'h4;
  localparam logic [3:0] STATES_REP_8 = 4'h5;
  localparam logic [3:0] STATES_REP_4 = 4'h6;
  localparam logic [3:0] STATES_REP_2 = 4'h7;
  localparam logic [3:0] STATES_REP_1 = 4'h8;

  // Encoded term base: factor byte is this minus the bit index
  localparam logic [7:0] FACTOR_BASE = 8'h1F;

  // Index of the least significant one, zero when none
  function automatic logic [4:0] lsb_index(input logic [31:0] v);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction : lsb_index

  // Byte-enable merge of a write into an old word
  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : be_merge

endpackage : bitops_pkg

/* rtl/pitch_factor_unit.sv */
// Encodes a row stride into a linear-conversion factor and its run length
module pitch_factor_unit
  import bitops_pkg::*;
(
  input wire logic [31:0] pitch,
  output logic [15:0] factor,
  output logic [3:0] states
);

  logic [31:0] rest;
  logic [31:0] rest2;
  logic [4:0] low_idx;
  logic [4:0] high_idx;

  // Strip the lowest term, then look at what remains
  always_comb begin
    rest = pitch & (pitch - 32'h0000_0001);
    rest2 = rest & (rest - 32'h0000_0001);
    low_idx = lsb_index(pitch);
    high_idx = lsb_index(rest);
    factor = FACTOR_RESET;
    states = STATES_FACTOR_OTHER;
    if (pitch != WORD_RESET && rest == WORD_RESET) begin
      factor = {8'h00, FACTOR_BASE - {3'h0, low_idx}};
      states = STATES_FACTOR_POW2;
    end else if (pitch != WORD_RESET && rest2 == WORD_RESET) begin
      // Larger term in the low byte
      factor = {FACTOR_BASE - {3'h0, low_idx}, FACTOR_BASE - {3'h0, high_idx}};
      states = STATES_FACTOR_TWO;
    end
  end

endmodule : pitch_factor_unit

/* bench/bitops_core_assertions.sv */
module bitops_core_assertions
  import bitops_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [31:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  // Read finishing now, and the 16-bit registers
  logic rd_done;
  logic narrow;
  assign rd_done = read && !waitrequest;
  assign narrow = address inside {ADDR_PIX_WIDTH, ADDR_SRC_FACTOR, ADDR_DST_FACTOR, ADDR_MSK_FACTOR};

  property p_wait_one_cycle;
    waitrequest && !(write && address == ADDR_COMMAND) |=> !waitrequest;
  endproperty
  a_wait_one_cycle: assert property (p_wait_one_cycle) else $error("plain request waited over one cycle");

  property p_read_one_wait;
    $rose(read) |-> waitrequest ##1 !waitrequest;
  endproperty
  a_read_one_wait: assert property (p_read_one_wait) else $error("read not answered after one wait");

  property p_write_one_wait;
    $rose(write) && address != ADDR_COMMAND |-> waitrequest ##1 !waitrequest;
  endproperty
  a_write_one_wait: assert property (p_write_one_wait) else $error("write not answered after one wait");

  property p_cmd_stall_bounded;
    write && address == ADDR_COMMAND && waitrequest |-> ##[1:16] !waitrequest;
  endproperty
  a_cmd_stall_bounded: assert property (p_cmd_stall_bounded) else $error("command stall too long");

  property p_unmapped_zero;
    rd_done && address[31:28] != 4'hC |-> readdata == 32'h0000_0000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

  property p_narrow_upper;
    rd_done && narrow |-> readdata[31:16] == 16'h0000;
  endproperty
  a_narrow_upper: assert property (p_narrow_upper) else $error("narrow register upper bits set");

  property p_status_upper;
    rd_done && address == ADDR_STATUS |-> readdata[31:2] == 30'h0000_0000;
  endproperty
  a_status_upper: assert property (p_status_upper) else $error("status spare bits set");

  property p_readdata_holds;
    !read |=> $stable(readdata);
  endproperty
  a_readdata_holds: assert property (p_readdata_holds) else $error("read data moved while idle");
endmodule : bitops_core_assertions

bind bitops_core bitops_core_assertions u_chk (.core_clk(core_clk), .reset_n(reset_n), .address(address),
  .read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest));

/* bench/rotate_bitscan_pixel_pitch_ops_bench.sv */
module rotate_bitscan_pixel_pitch_ops_bench
  import bitops_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [31:0] address = 32'h0000_0000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] readdata;
  logic waitrequest;
  logic [31:0] rv, t, s, f, e;
  logic [31:0] tv[5] = '{32'h0000_000F, 32'hF000_0000, 32'hF000_0000, 32'hF000_0000, 32'h0000_0000};
  logic [31:0] cv[5] = '{32'h0000_0000, 32'h0000_0004, 32'h0000_0005, 32'h0000_001F, 32'h0000_0005};
  logic [31:0] pv[5] = '{32'h0000_1000, 32'h0000_0400, 32'h0000_1400, 32'h0000_0019, 32'h8000_0001};
  logic [31:0] sa[3] = '{ADDR_SRC_STRIDE, ADDR_DST_STRIDE, ADDR_MSK_STRIDE};
  logic [31:0] fa[3] = '{ADDR_SRC_FACTOR, ADDR_DST_FACTOR, ADDR_MSK_FACTOR};
  logic [3:0] cm[3] = '{CMD_LOAD_SRC_FACTOR, CMD_LOAD_DST_FACTOR, CMD_LOAD_MSK_FACTOR};
  int error_cnt = 0;
  int checked = 0;
  int c;
  int lat;
  int rs[6] = '{8, 7, 6, 5, 4, 2};

  bitops_core u_dut (.core_clk(core_clk), .reset_n(reset_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest));

  // Core clock
  always #2 core_clk = ~core_clk;

  // Verdict and end of run
  task automatic end_of_test();
    if (error_cnt == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  // Compare seen against expected
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  // One bus transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [3:0] be);
    int k;
    k = 0;
    @(posedge core_clk);
    address <= a;
    read <= ~wr;
    write <= wr;
    writedata <= d;
    byteenable <= be;
    do begin
      @(posedge core_clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 100);
    lat = k;
    rv = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      chk("bus_timeout", 32'h1, 32'h0);
      end_of_test();
    end
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask : wr

  task automatic rd(input string n, input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hF);
    chk(n, rv, exp);
  endtask : rd

  // Command, then memory sync, then poll status until clear; the sync write waits out n states
  task automatic run(input logic [3:0] cmd, input int n);
    int k;
    k = 0;
    wr(ADDR_COMMAND, {28'h0, cmd});
    wr(ADDR_COMMAND, {28'h0, CMD_MEMORY_SYNC});
    chk("states", 32'(lat), 32'(n + 1));
    do begin
      bus(1'b0, ADDR_STATUS, 32'h0, 4'hF);
      k++;
    end while (rv !== 32'h0 && k < 50);
    chk("status_idle", rv, 32'h0);
    if (rv !== 32'h0) begin
      end_of_test();
    end
  endtask : run

  function automatic logic [31:0] rot(input logic [31:0] v, input int n);
    return (n == 0) ? v : ((v << n) | (v >> (32 - n)));
  endfunction : rot

  function automatic logic [31:0] rep(input logic [31:0] v, input int w);
    logic [31:0] r;
    for (int i = 0; i < 32; i++) begin
      r[i] = v[i % w];
    end
    return r;
  endfunction : rep

  // Factor bytes are 31 minus term index, larger term in the low byte
  function automatic logic [15:0] fac(input logic [31:0] p);
    int hi, lo, ones;
    ones = 0;
    hi = 0;
    lo = 0;
    for (int i = 0; i < 32; i++) begin
      if (p[i]) begin
        ones++;
        hi = i;
        if (ones == 1) begin
          lo = i;
        end
      end
    end
    if (ones == 1) begin
      return {8'h00, 8'(31 - hi)};
    end
    return (ones == 2) ? {8'(31 - lo), 8'(31 - hi)} : 16'h0000;
  endfunction : fac

  // Main sequence
  initial begin
    void'($urandom(29));
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    rd("pix_reset", ADDR_PIX_WIDTH, {16'h0, PIX_WIDTH_RESET});
    rd("unmapped", 32'hC000_0500, 32'h0);
    rd("unmapped_low", 32'h4000_0130, 32'h0);
    wr(ADDR_MSK_FACTOR, 32'hFFFF_ABCD);
    rd("factor_rw", ADDR_MSK_FACTOR, 32'h0000_ABCD);
    wr(ADDR_TARGET, 32'h1122_3344);
    bus(1'b1, ADDR_TARGET, 32'hAABB_CCDD, 4'h5);
    rd("target_lanes", ADDR_TARGET, 32'h11BB_33DD);
    // Rotate: table cases, then random words with junk in the upper count bits
    for (int i = 0; i < 40; i++) begin
      t = (i < 5) ? tv[i] : $urandom;
      s = (i < 5) ? cv[i] : $urandom;
      f = $urandom;
      c = int'(s[4:0]);
      e = rot(t, c);
      wr(ADDR_FLAGS, f);
      wr(ADDR_TARGET, t);
      wr(ADDR_OPERAND, s);
      wr(ADDR_COMMAND, {28'h0, CMD_CIRCULAR_SHIFT});
      rd("rot_busy", ADDR_STATUS, 32'h0);
      rd("rot_result", ADDR_TARGET, e);
      rd("rot_flags", ADDR_FLAGS, {f[31], (c != 0) & e[0], e == 32'h0, f[28:0]});
    end
    // Lowest set bit, empty and top-bit sources first
    for (int i = 0; i < 20; i++) begin
      s = (i == 0) ? 32'h0 : (i == 1) ? 32'h8000_0000 : $urandom << i;
      f = $urandom;
      e = 32'h0;
      for (int b = 31; b >= 0; b--) begin
        if (s[b]) begin
          e = 32'(b);
        end
      end
      wr(ADDR_FLAGS, f);
      wr(ADDR_OPERAND, s);
      wr(ADDR_COMMAND, {28'h0, CMD_LOWEST_SET_BIT});
      rd("scan_result", ADDR_TARGET, e);
      rd("scan_flags", ADDR_FLAGS, {f[31:30], s == 32'h0, f[28:0]});
    end
    // Replicate at every legal pixel width
    for (int i = 0; i < 6; i++) begin
      t = $urandom;
      f = $urandom;
      wr(ADDR_PIX_WIDTH, 32'(1 << i));
      wr(ADDR_FLAGS, f);
      wr(ADDR_TARGET, t);
      run(CMD_PIXEL_REPLICATE, rs[i]);
      rd("rep_result", ADDR_TARGET, rep(t, 1 << i));
      rd("rep_flags", ADDR_FLAGS, f);
    end
    // Carry force, then an unused code that must do nothing
    f = $urandom & 32'hBFFF_FFFF;
    wr(ADDR_FLAGS, f);
    run(CMD_CARRY_FORCE, 1);
    wr(ADDR_COMMAND, 32'h0000_000F);
    rd("carry_force", ADDR_FLAGS, f | 32'h4000_0000);
    // Pitch factors for every array and stride class
    for (int i = 0; i < 18; i++) begin
      s = (i < 15) ? pv[i % 5] : $urandom;
      wr(sa[i % 3], s);
      run(cm[i % 3], ($countones(s) == 1) ? 4 : ($countones(s) == 2) ? 6 : 3);
      rd("factor", fa[i % 3], {16'h0, fac(s)});
    end
    rd("factor_flags", ADDR_FLAGS, f | 32'h4000_0000);
    end_of_test();
  end
endmodule : rotate_bitscan_pixel_pitch_ops_bench
